/* File: shared/adc_result_pkg.sv */
package adc_result_pkg;

    // Register map (byte offsets on the plain register port)
    localparam logic [7:0] ADDR_RESULT_HIGH  = 8'h3d;
    localparam logic [7:0] ADDR_RESULT_LOW   = 8'h3e;
    localparam logic [7:0] ADDR_CLOCK_FORMAT = 8'h3f;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h40;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h41;

    // converter_clock_and_format field positions
    localparam int PRESCALE_LSB   = 5;
    localparam int PRESCALE_MSB   = 7;
    localparam int CLK_SELECT_BIT = 4;
    localparam int JUSTIFY_HI_BIT = 3;
    localparam int JUSTIFY_LO_BIT = 2;

    // Reset: crystal clock, divide by 1, right justified
    localparam logic [7:0] CLOCK_FORMAT_RESET = 8'h04;
    localparam logic [7:0] RESULT_RESET       = 8'h00;

    // Interrupt status bits
    localparam int IRQ_COMPLETE_BIT = 0;
    localparam int IRQ_LOST_BIT     = 1;
    localparam int IRQ_BITS         = 2;

    localparam int RESULT_WIDTH   = 10;
    localparam int PRESCALE_WIDTH = 4;
    localparam logic [3:0] PRESCALE_MAX = 4'hf;

    typedef enum logic [1:0] {
        FMT_TRUNCATED,
        FMT_RIGHT,
        FMT_LEFT,
        FMT_LEFT_SIGNED
    } justify_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic                    valid;
        logic [RESULT_WIDTH-1:0] value;
    } conv_result_s;

endpackage : adc_result_pkg

/* File: rtl/adc_clock_prescaler.sv */
`timescale 1ns/1ps
module adc_clock_prescaler (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       crystal_tick,
    input  wire logic       input_clock_select,
    input  wire logic [2:0] clock_prescale_field,
    output logic            adc_clock_tick
);
    import adc_result_pkg::*;

    typedef struct packed {
        logic [PRESCALE_WIDTH-1:0] count;
        logic                      tick;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic   src_tick;
    logic [PRESCALE_WIDTH-1:0] limit;

    always_comb begin
        // Bus clock is every cycle; crystal arrives as an enable pulse
        src_tick = input_clock_select | crystal_tick;  // R11
        case (clock_prescale_field)  // R10
            3'b000:  limit = 4'h0;
            3'b001:  limit = 4'h1;
            3'b010:  limit = 4'h3;
            3'b011:  limit = 4'h7;
            default: limit = PRESCALE_MAX;
        endcase
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (src_tick) begin
            if (state_reg.count >= limit) begin
                state_next.count = '0;
                state_next.tick  = 1'b1;  // R10
            end else begin
                state_next.count = state_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign adc_clock_tick = state_reg.tick;

endmodule : adc_clock_prescaler

/* File: rtl/adc_result_formatter.sv */
`timescale 1ns/1ps
module adc_result_formatter (
    input  wire logic [adc_result_pkg::RESULT_WIDTH-1:0] value,
    input  wire adc_result_pkg::justify_e                mode,
    output logic [7:0]                                   high_byte,
    output logic [7:0]                                   low_byte
);
    import adc_result_pkg::*;

    always_comb begin
        case (mode)  // R14
            FMT_TRUNCATED: begin
                high_byte = 8'h00;           // R2
                low_byte  = value[9:2];      // R2
            end
            FMT_RIGHT: begin
                high_byte = {6'h00, value[9:8]};  // R4
                low_byte  = value[7:0];           // R4
            end
            FMT_LEFT: begin
                high_byte = value[9:2];           // R5
                low_byte  = {value[1:0], 6'h00};  // R5
            end
            default: begin
                high_byte = {~value[9], value[8:2]};  // R6
                low_byte  = {value[1:0], 6'h00};
            end
        endcase
    end

endmodule : adc_result_formatter

/* File: rtl/adc_result_format_and_clock.sv */
// Overview of operation
// R1: Result shown as high and low bytes
// R2: Truncated: bits 9..2 low, high zero
// R3: Truncated: low byte always refreshed, no lock
// R4: Right justified: 9..8 high, 7..0 low
// R5: Left justified: 9..2 high, 1..0 low top
// R6: Signed left: invert MSB in high bit 7
// R7: Justified formats update both bytes
// R8: High byte read freezes the low byte
// R9: Results discarded until low byte read
// R10: Prescale 1,2,4,8, top bit gives 16
// R11: Select bit 1 bus, 0 crystal; reset crystal
// R12: Software keeps ADC clock 32 kHz..2 MHz
// R13: Crystal source only if at least 1 MHz
// R14: Mode field decodes four justification formats
// R15: Reset selects right justified format
// R16: Low byte read clears complete flag, irq
// R17: Low byte read releases the read lock
// R18: Result bytes read-only, reset to zero
`timescale 1ns/1ps
module adc_result_format_and_clock (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic [7:0]                           reg_addr,
    input  wire logic [7:0]                           reg_wdata,
    input  wire logic                                 reg_wr,
    input  wire logic                                 reg_rd,
    output logic [7:0]                                reg_rdata,
    input  wire adc_result_pkg::conv_result_s         conv_in,
    input  wire logic                                 crystal_reference_clock,
    output logic                                      adc_clock_tick,
    output logic                                      conversion_complete_flag,
    output logic                                      irq
);
    import adc_result_pkg::*;

    // Everything the block remembers, bar the prescaler's own count and tick in u_prescaler, lives in this one record
    typedef struct packed {
        logic [7:0]          result_high_byte;
        logic [7:0]          result_low_byte;
        logic [7:0]          clock_format;
        logic                read_lock;
        logic                complete;
        logic [IRQ_BITS-1:0] irq_status;
        logic [IRQ_BITS-1:0] irq_mask;
        logic [7:0]          rdata;
        logic                irq;
        logic                adc_tick;
        logic [2:0]          xtal_sync;
        logic                xtal_level;
        logic                xtal_tick;
    } state_s;

    state_s              state_reg;
    state_s              state_next;

    // Register port gathered into one request record
    reg_req_s            req;

    // Decoded fields of converter_clock_and_format
    justify_e            mode;
    logic                justified;
    logic                input_clock_select;
    logic [2:0]          clock_prescale_field;

    // Formatter view of the incoming result
    logic [7:0]          fmt_high;
    logic [7:0]          fmt_low;

    // Prescaler pulse, registered once more before it leaves
    logic                prescale_tick;

    // Register port decode
    logic                hit_high;
    logic                hit_low;
    logic                hit_clock;
    logic                hit_status;
    logic                hit_mask;
    logic                read_high;
    logic                read_low;
    logic                write_clock;
    logic                write_status;
    logic                write_mask;
    logic [7:0]          read_mux;

    // Result acceptance
    logic                lock_active;
    logic                take_result;
    logic                lost_result;

    // Sticky status, worked out one bit at a time
    logic [IRQ_BITS-1:0] irq_events;
    logic [IRQ_BITS-1:0] irq_clear;
    logic [IRQ_BITS-1:0] irq_status_next;

    // Crystal pin synchroniser view
    logic                xtal_agree;
    logic                xtal_rise;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    assign mode                 = justify_e'({state_reg.clock_format[JUSTIFY_HI_BIT],
                                              state_reg.clock_format[JUSTIFY_LO_BIT]});  // R14
    assign justified            = (mode != FMT_TRUNCATED);
    assign input_clock_select   = state_reg.clock_format[CLK_SELECT_BIT];
    assign clock_prescale_field = state_reg.clock_format[PRESCALE_MSB:PRESCALE_LSB];

    assign hit_high   = (req.addr == ADDR_RESULT_HIGH);
    assign hit_low    = (req.addr == ADDR_RESULT_LOW);
    assign hit_clock  = (req.addr == ADDR_CLOCK_FORMAT);
    assign hit_status = (req.addr == ADDR_IRQ_STATUS);
    assign hit_mask   = (req.addr == ADDR_IRQ_MASK);

    assign read_high    = req.rd && hit_high;
    assign read_low     = req.rd && hit_low;
    assign write_clock  = req.wr && hit_clock;
    assign write_status = req.wr && hit_status;
    assign write_mask   = req.wr && hit_mask;

    // A result landing in the cycle of the high byte read is dropped too,
    // otherwise the pair read back would mix two samples
    assign lock_active = justified && (state_reg.read_lock || read_high);  // R8 R9
    assign take_result = conv_in.valid && !lock_active;                     // R3 R9
    assign lost_result = conv_in.valid && lock_active;                      // R9

    // Second and third flops must agree before the level is believed
    assign xtal_agree = (state_reg.xtal_sync[2] == state_reg.xtal_sync[1]);
    assign xtal_rise  = xtal_agree && state_reg.xtal_sync[2] && !state_reg.xtal_level;

    always_comb begin
        case (req.addr)
            ADDR_RESULT_HIGH:  read_mux = state_reg.result_high_byte;  // R1
            ADDR_RESULT_LOW:   read_mux = state_reg.result_low_byte;   // R1
            ADDR_CLOCK_FORMAT: read_mux = state_reg.clock_format;
            ADDR_IRQ_STATUS:   read_mux = {{(8-IRQ_BITS){1'b0}}, state_reg.irq_status};
            ADDR_IRQ_MASK:     read_mux = {{(8-IRQ_BITS){1'b0}}, state_reg.irq_mask};
            default:           read_mux = 8'h00;
        endcase
    end

    assign irq_events[IRQ_COMPLETE_BIT] = take_result;
    assign irq_events[IRQ_LOST_BIT]     = lost_result;

    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < IRQ_BITS; bit_idx++) begin : g_status
            // Write one to clear; a low byte read also clears the completion bit
            assign irq_clear[bit_idx] = (write_status && req.wdata[bit_idx])
                                     || (read_low && (bit_idx == IRQ_COMPLETE_BIT));  // R16
            // An event in the same cycle as its clear wins
            assign irq_status_next[bit_idx] = irq_events[bit_idx]
                || (state_reg.irq_status[bit_idx] && !irq_clear[bit_idx]);
        end
    endgenerate

    adc_result_formatter u_formatter (
        .value     (conv_in.value),
        .mode      (mode),
        .high_byte (fmt_high),
        .low_byte  (fmt_low)
    );

    adc_clock_prescaler u_prescaler (
        .clk                  (clk),
        .reset_n              (reset_n),
        .crystal_tick         (state_reg.xtal_tick),
        .input_clock_select   (input_clock_select),
        .clock_prescale_field (clock_prescale_field),
        .adc_clock_tick       (prescale_tick)
    );

    always_comb begin
        state_next = state_reg;

        // Crystal pin: three flops, edge counted when second and third agree
        state_next.xtal_sync = {state_reg.xtal_sync[1:0], crystal_reference_clock};
        if (xtal_agree) begin
            state_next.xtal_level = state_reg.xtal_sync[2];
        end
        state_next.xtal_tick = xtal_rise;

        // Read data stands in the cycle after the strobe only
        state_next.rdata = req.rd ? read_mux : 8'h00;

        // Result bytes have no write path at all
        if (write_clock) begin  // R18
            state_next.clock_format = req.wdata;
        end
        if (write_mask) begin
            state_next.irq_mask = req.wdata[IRQ_BITS-1:0];
        end

        if (read_high && justified) begin
            state_next.read_lock = 1'b1;  // R8
        end
        if (read_low) begin
            state_next.read_lock = 1'b0;  // R17
        end

        // Writing the clock register also ends a pending completion
        if (read_low || write_clock) begin
            state_next.complete = 1'b0;  // R16
        end

        // Formatter already zeroes the high byte in truncated format
        if (take_result) begin
            state_next.result_low_byte  = fmt_low;   // R3 R7
            state_next.result_high_byte = fmt_high;  // R2 R7
            state_next.complete         = 1'b1;
        end

        state_next.irq_status = irq_status_next;
        state_next.irq        = |(irq_status_next & state_reg.irq_mask);

        // One more flop keeps the tick output straight off a register
        state_next.adc_tick = prescale_tick;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg                  <= '0;
            state_reg.result_high_byte <= RESULT_RESET;        // R18
            state_reg.result_low_byte  <= RESULT_RESET;        // R18
            state_reg.clock_format     <= CLOCK_FORMAT_RESET;  // R15
        end else begin
            state_reg <= state_next;
        end
    end

    assign adc_clock_tick           = state_reg.adc_tick;
    assign reg_rdata                = state_reg.rdata;
    assign conversion_complete_flag = state_reg.complete;
    assign irq                      = state_reg.irq;

endmodule : adc_result_format_and_clock

/* File: testbench/adc_result_checker.sv */
`timescale 1ns/1ps
module adc_result_checker (
    input wire logic                         clk,
    input wire logic                         reset_n,
    input wire logic [7:0]                   reg_addr,
    input wire logic [7:0]                   reg_wdata,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [7:0]                   reg_rdata,
    input wire adc_result_pkg::conv_result_s conv_in,
    input wire logic                         conversion_complete_flag,
    input wire logic                         irq
);
    import adc_result_pkg::*;
    logic [7:0] cfg_reg;
    wire        rd_hi = reg_rd && reg_addr == ADDR_RESULT_HIGH;
    wire        rd_lo = reg_rd && reg_addr == ADDR_RESULT_LOW;
    // Shadow of the format field, so read checks know the active layout
    always_ff @(posedge clk) begin
        if (!reset_n)
            cfg_reg <= CLOCK_FORMAT_RESET;
        else if (reg_wr && reg_addr == ADDR_CLOCK_FORMAT)
            cfg_reg <= reg_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_flag_cause: assert property ($rose(conversion_complete_flag) |-> $past(conv_in.valid))
        else $error("complete flag without result");
    a_low_clears: assert property (rd_lo && !conv_in.valid |=> !conversion_complete_flag)
        else $error("low read kept flag");
    a_irq_cause: assert property ($rose(irq) |-> $past(conv_in.valid) || $past(reg_wr, 2))
        else $error("irq rose without cause");
    a_trunc_high: assert property (rd_hi && cfg_reg[3:2] == 2'h0 |=> reg_rdata == 8'h00)
        else $error("truncated high not zero");
    a_right_high: assert property (rd_hi && cfg_reg[3:2] == 2'h1 |=> reg_rdata[7:2] == 6'h00)
        else $error("right high upper bits set");
    a_left_low: assert property (rd_lo && cfg_reg[3] |=> reg_rdata[5:0] == 6'h00)
        else $error("left low lower bits set");
    a_trunc_accept: assert property (conv_in.valid && cfg_reg[3:2] == 2'h0 && !reg_wr
        |=> conversion_complete_flag)
        else $error("truncated result not taken");
    cover property (rd_hi ##1 rd_lo);
    cover property ($rose(irq));
    cover property (conv_in.valid && cfg_reg[3:2] == 2'h3);
endmodule : adc_result_checker

bind adc_result_format_and_clock adc_result_checker u_chk (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_in(conv_in), .irq(irq),
    .conversion_complete_flag(conversion_complete_flag));

/* File: testbench/conv_source.sv */
`timescale 1ns/1ps
module conv_source (
    input  wire logic                   clk,
    output adc_result_pkg::conv_result_s conv_in,
    output logic                        crystal_reference_clock
);
    import adc_result_pkg::*;
    // Crystal at 25 MHz, offset so its edges never meet the bus clock edges
    initial begin
        conv_in = '0;
        crystal_reference_clock = 1'h0;
        #1;
        forever #20 crystal_reference_clock = ~crystal_reference_clock;
    end
    task automatic send(input logic [9:0] v);
        @(posedge clk);
        conv_in <= '{valid: 1'h1, value: v};
        @(posedge clk);
        conv_in <= '{valid: 1'h0, value: ~v};
        #1;
    endtask : send
endmodule : conv_source

/* File: testbench/adc_result_format_and_clock_tb.sv */
`timescale 1ns/1ps
module adc_result_format_and_clock_tb;
    import adc_result_pkg::*;
    logic         clk = 1'h0;
    logic         reset_n = 1'h0;
    logic [7:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [7:0]   reg_rdata;
    conv_result_s conv_in;
    logic         xtal;
    logic         tick;
    logic         flag;
    logic         irq;
    int           bad_count = 0;
    int           checks = 0;
    always #2 clk = ~clk;
    conv_source u_src (.clk(clk), .conv_in(conv_in), .crystal_reference_clock(xtal));
    adc_result_format_and_clock u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_in(conv_in), .crystal_reference_clock(xtal), .adc_clock_tick(tick),
        .conversion_complete_flag(flag), .irq(irq));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(n, e, reg_rdata);
    endtask : rc
    function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
        case (m)
            2'h0: fmt = {8'h00, v[9:2]};
            2'h1: fmt = {6'h00, v};
            2'h2: fmt = {v, 6'h00};
            default: fmt = {~v[9], v[8:0], 6'h00};
        endcase
    endfunction : fmt
    task automatic reset_values;
        rc(ADDR_RESULT_HIGH, 8'h00, "high");
        wr(ADDR_RESULT_HIGH, 8'hff);
        rc(ADDR_RESULT_HIGH, 8'h00, "high");
        rc(ADDR_RESULT_LOW, 8'h00, "low");
        rc(ADDR_CLOCK_FORMAT, CLOCK_FORMAT_RESET, "clock");
        rc(8'h50, 8'h00, "unmapped");
    endtask : reset_values
    task automatic formats;
        logic [15:0] e;
        for (int m = 0; m < 4; m++) begin
            e = fmt(m[1:0], 10'h2c5);
            wr(ADDR_CLOCK_FORMAT, {3'h0, 1'h1, m[1:0], 2'h0});
            u_src.send(10'h2c5);
            chk("flag", 8'h01, {7'h00, flag});
            rc(ADDR_RESULT_HIGH, e[15:8], "high");
            rc(ADDR_RESULT_LOW, e[7:0], "low");
            chk("flag", 8'h00, {7'h00, flag});
        end
    endtask : formats
    task automatic lock_and_irq;
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_CLOCK_FORMAT, 8'h14);
        u_src.send(10'h155);
        @(posedge clk);
        #1 chk("irq", 8'h01, {7'h00, irq});
        rc(ADDR_RESULT_HIGH, 8'h01, "high");
        u_src.send(10'h2aa);
        rc(ADDR_RESULT_LOW, 8'h55, "low");
        @(posedge clk);
        #1 chk("irq", 8'h00, {7'h00, irq});
        rc(ADDR_IRQ_STATUS, 8'h02, "status");
        wr(ADDR_IRQ_STATUS, 8'h02);
        u_src.send(10'h3f0);
        rc(ADDR_RESULT_HIGH, 8'h03, "high");
        rc(ADDR_RESULT_LOW, 8'hf0, "low");
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CLOCK_FORMAT, 8'h10);
        u_src.send(10'h155);
        rc(ADDR_RESULT_HIGH, 8'h00, "high");
        u_src.send(10'h2aa);
        rc(ADDR_RESULT_LOW, 8'haa, "low");
    endtask : lock_and_irq
    // Settle first so a count left over from the old ratio cannot leak in
    task automatic count_ticks(input int c, output int n);
        repeat (16) @(posedge clk);
        n = 0;
        repeat (c) begin
            @(posedge clk);
            #1 n += tick;
        end
    endtask : count_ticks
    task automatic prescale;
        int n;
        for (int f = 0; f < 8; f++) begin
            wr(ADDR_CLOCK_FORMAT, {f[2:0], 5'h10});
            count_ticks(64, n);
            chk("ticks", 8'(64 >> (f > 3 ? 4 : f)), 8'(n));
        end
        // Rates are scaled for simulation; real software keeps 32 kHz..2 MHz
        wr(ADDR_CLOCK_FORMAT, 8'h00);
        count_ticks(200, n);
        chk("crystal ticks", 8'h14, 8'(n));
    endtask : prescale
    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    initial begin
        reg_addr <= 8'h00;
        reg_wdata <= 8'h00;
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
        reset_values();
        formats();
        lock_and_irq();
        prescale();
        results();
    end
    initial begin
        #400000;
        bad_count++;
        results();
    end
endmodule : adc_result_format_and_clock_tb
